/* logic/sarcs_pkg.sv */
// shared constants, types and coding functions of the sar conversion sequencer
//
// Contract
// - short-cycle tap on bit N+1 stops after N
// - 10/8 bit runs need faster clock setting
// - host never exceeds max rate for resolution
// - results presented in complementary coding
// - external mode: trigger pulses step bit decisions
// - external pulse rate below internal clock rate
// - external pulse low time 100 to 300 ns
// - external N-bit conversion completes after N+1 pulses
// - free-running pulses give result per N+1; eoc gating
// - buffered input: settle before trigger falling edge (chained runs of a continuous external pulse train start with no settle)
// - trigger falling edge restarts a conversion (internal mode only here; in external mode it only starts one from idle)
// - eoc high in reset and conversion, low done
// - parallel result held until next trigger
// - decisions shifted out nrz, msb first, complemented
package sarcs_pkg;

	localparam int         DATA_W     = 12;
	localparam logic [11:0] MSB_TRIAL = 12'h800;
	localparam logic [11:0] DATA_RST  = 12'hfff;
	localparam logic [3:0]  BITS_MAX  = 4'hc;
	localparam logic [3:0]  TAP_FULL  = 4'hd;   // tap on the +5V rail: all bits
	localparam logic [3:0]  TAP_MIN   = 4'h2;

	// clock rate strap settings
	localparam logic [1:0] RATE_GND  = 2'h0;
	localparam logic [1:0] RATE_5V   = 2'h1;
	localparam logic [1:0] RATE_15V  = 2'h2;

	// resolution selections of the host
	localparam logic [1:0] RES_12    = 2'h0;
	localparam logic [1:0] RES_10    = 2'h1;
	localparam logic [1:0] RES_8     = 2'h2;
	localparam logic [3:0] BITS_10   = 4'ha;
	localparam logic [3:0] BITS_8    = 4'h8;

	// output coding selections
	localparam logic [1:0] CODE_UNI  = 2'h0;
	localparam logic [1:0] CODE_COB  = 2'h1;
	localparam logic [1:0] CODE_CTC  = 2'h2;

	// timing, in ns and in 5 ns cycles
	localparam int CLK_PERIOD_NS  = 5;
	localparam int START_LOW_NS   = 200;
	localparam int EXT_PERIOD_NS  = 1000;
	localparam int SETTLE_NS      = 3000;
	localparam int BIT_GND_NS     = 667;
	localparam int BIT_5V_NS      = 556;
	localparam int BIT_15V_NS     = 455;
	localparam logic [9:0] START_LOW_CYC  = 10'((START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [9:0] EXT_PERIOD_CYC = 10'((EXT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [9:0] EXT_HIGH_CYC   = 10'(EXT_PERIOD_CYC - START_LOW_CYC);
	localparam logic [9:0] SETTLE_CYC     = 10'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] BIT_GND_CYC    = 8'((BIT_GND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] BIT_5V_CYC     = 8'((BIT_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] BIT_15V_CYC    = 8'((BIT_15V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// host register map and fields
	localparam logic [3:0] REG_CTRL  = 4'h0;
	localparam logic [3:0] REG_STAT  = 4'h4;
	localparam logic [3:0] REG_MASK  = 4'h8;
	localparam logic [3:0] REG_RSLT  = 4'hc;
	localparam int CTRL_GO       = 0;
	localparam int CTRL_EXT      = 1;
	localparam int CTRL_CONT     = 2;
	localparam int CTRL_BUF      = 3;
	localparam int CTRL_RES_LSB  = 4;
	localparam int CTRL_CODE_LSB = 6;
	localparam int STAT_DONE     = 0;
	localparam int STAT_OVR      = 1;
	localparam int RSLT_BUSY     = 12;

	typedef enum logic [1:0] {
		DEV_IDLE = 2'b00,
		DEV_CONV = 2'b01
	} sarcs_dev_state_t;

	typedef enum logic [2:0] {
		HST_IDLE   = 3'b000,
		HST_SETTLE = 3'b001,
		HST_LOW    = 3'b010,
		HST_HIGH   = 3'b011,
		HST_WAIT   = 3'b100
	} sarcs_hst_state_t;

	// bits resolved for a short-cycle tap (bit number N+1)
	function automatic logic [3:0] tap_bits(input logic [3:0] tap);
		if (tap >= TAP_MIN && tap <= TAP_FULL)
			return 4'(tap - 4'h1);
		return BITS_MAX;
	endfunction

	// resolution selection to bit count
	function automatic logic [3:0] res_bits(input logic [1:0] res);
		if (res == RES_10)
			return BITS_10;
		if (res == RES_8)
			return BITS_8;
		return BITS_MAX;
	endfunction

	// resolution selection to clock rate strap
	function automatic logic [1:0] res_rate(input logic [1:0] res);
		if (res == RES_10)
			return RATE_5V;
		if (res == RES_8)
			return RATE_15V;
		return RATE_GND;
	endfunction

	// internal bit period in cycles for a rate strap
	function automatic logic [7:0] rate_div(input logic [1:0] rate);
		if (rate == RATE_5V)
			return BIT_5V_CYC;
		if (rate == RATE_15V)
			return BIT_15V_CYC;
		return BIT_GND_CYC;
	endfunction

	// true binary sar result to complementary output code
	function automatic logic [11:0] encode(input logic [11:0] r, input logic [1:0] code);
		if (code == CODE_CTC)
			return {r[11], ~r[10:0]};
		return ~r;
	endfunction

endpackage

/* logic/sarcs_if.sv */
// link between host logic and the converter sequencer
`timescale 1ns/1ps
interface sarcs_if;
	logic        start_n;    // conversion trigger, active low edge
	logic        ext_mode;   // trigger pulses act as bit clock
	logic [3:0]  sc_tap;     // short-cycle tap, bit number N+1
	logic [1:0]  clk_rate;   // clock rate strap
	logic [1:0]  code_sel;   // output coding
	logic        eoc;        // end of conversion status
	logic [11:0] data;       // parallel result
	logic        ser;        // nrz serial decisions

	modport dev (
		input  start_n, ext_mode, sc_tap, clk_rate, code_sel,
		output eoc, data, ser
	);
	modport host (
		output start_n, ext_mode, sc_tap, clk_rate, code_sel,
		input  eoc, data, ser
	);
endinterface

/* logic/sarcs_tick_gen.sv */
// internal bit clock divider of the sequencer
`timescale 1ns/1ps
module sarcs_tick_gen #(
	parameter int W = 8
) (
	// clock, reset, enable
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         ce_i,
	// control
	input  wire logic         restart_i,
	input  wire logic [W-1:0] div_i,
	// tick out
	output logic              tick_o
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic         next_tick;

	// restart aligns the first period to the trigger edge
	always_comb begin
		next_cnt  = W'(cnt + 1'b1);
		next_tick = 1'b0;
		if (restart_i) begin
			next_cnt = '0;
		end else if (next_cnt >= div_i) begin
			next_cnt  = '0;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt    <= '0;
			tick_o <= 1'b0;
		end else if (ce_i) begin
			cnt    <= next_cnt;
			tick_o <= next_tick;
		end
	end
endmodule // sarcs_tick_gen

/* logic/sarcs_device.sv */
// converter end: successive approximation sequencing, coding and status
`timescale 1ns/1ps
module sarcs_device (
	// clock, reset, enable
	input  wire logic  clk_i,
	input  wire logic  rst_n_i,
	input  wire logic  ce_i,
	// link to host logic
	sarcs_if.dev       lnk,
	// analog side: comparator decision for the current trial
	input  wire logic  cmp_i,
	// analog side: dac trial code, true binary
	output logic [11:0] trial_o,
	// observation
	output logic        bit_clk_o,
	output logic        busy_o
);

	sarcs_pkg::sarcs_dev_state_t state;
	sarcs_pkg::sarcs_dev_state_t next_state;

	logic [11:0] sar;
	logic [11:0] mask;
	logic [3:0]  left;
	logic        start_q;
	logic        eoc;
	logic [11:0] data;
	logic        ser;

	logic [11:0] next_sar;
	logic [11:0] next_mask;
	logic [11:0] next_trial;
	logic [3:0]  next_left;
	logic        next_eoc;
	logic [11:0] next_data;
	logic        next_ser;
	logic        next_busy;

	logic        fall;
	logic        begin_conv;
	logic        tick;
	logic        itick;
	logic [7:0]  div;

	// trigger edge; inputs are synchronous so one stage is enough
	assign fall = start_q & ~lnk.start_n;

	// a falling edge restarts in internal mode; in external mode it
	// only starts from idle, later edges step the bits
	assign begin_conv = fall & (state == sarcs_pkg::DEV_IDLE | ~lnk.ext_mode);

	// bit clock: external pulses or internal divider
	assign tick = lnk.ext_mode ? fall : itick;

	// rate strap picks the internal period
	assign div = sarcs_pkg::rate_div(lnk.clk_rate);

	// internal bit clock, realigned on every start
	sarcs_tick_gen #(
		.W (8)
	) u_tick (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.restart_i (begin_conv),
		.div_i     (div),
		.tick_o    (itick)
	);

	// link outputs straight from their flops
	assign lnk.eoc  = eoc;
	assign lnk.data = data;
	assign lnk.ser  = ser;

	// sequencing: one decision per bit period, msb first
	always_comb begin
		next_state = state;
		next_sar   = sar;
		next_mask  = mask;
		next_trial = trial_o;
		next_left  = left;
		next_eoc   = eoc;
		next_data  = data;
		next_ser   = ser;
		case (state)
			sarcs_pkg::DEV_IDLE: begin
				if (begin_conv) begin
					next_state = sarcs_pkg::DEV_CONV;
					next_sar   = '0;
					next_mask  = sarcs_pkg::MSB_TRIAL;
					next_trial = sarcs_pkg::MSB_TRIAL;
					next_left  = sarcs_pkg::tap_bits(lnk.sc_tap);
					next_eoc   = 1'b1;
				end
			end
			sarcs_pkg::DEV_CONV: begin
				if (begin_conv) begin
					// mid-conversion trigger: throw away partial bits
					next_sar   = '0;
					next_mask  = sarcs_pkg::MSB_TRIAL;
					next_trial = sarcs_pkg::MSB_TRIAL;
					next_left  = sarcs_pkg::tap_bits(lnk.sc_tap);
					next_eoc   = 1'b1;
				end else if (tick) begin
					// keep the trial bit when input is at or above it
					next_sar   = cmp_i ? trial_o : sar;
					next_ser   = ~cmp_i;
					next_mask  = mask >> 1;
					next_trial = next_sar | next_mask;
					next_left  = 4'(left - 4'h1);
					if (left == 4'h1) begin
						// last decided bit closes the run: N periods
						// internally, or N+1 pulses with the start pulse
						next_state = sarcs_pkg::DEV_IDLE;
						next_trial = next_sar;
						next_data  = sarcs_pkg::encode(next_sar, lnk.code_sel);
						next_eoc   = 1'b0;
					end
				end
			end
			default: begin
				next_state = sarcs_pkg::DEV_IDLE;
			end
		endcase
	end

	// busy mirrors the state in the same cycle, registered from next_state
	always_comb begin
		next_busy = (next_state == sarcs_pkg::DEV_CONV);
	end

	// state registers; data only change at completion so a slow
	// reader sees a stable word until the next trigger
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state     <= sarcs_pkg::DEV_IDLE;
			sar       <= '0;
			mask      <= '0;
			trial_o   <= '0;
			left      <= '0;
			start_q   <= 1'b1;
			eoc       <= 1'b1;
			data      <= sarcs_pkg::DATA_RST;
			ser       <= 1'b1;
			bit_clk_o <= 1'b0;
			busy_o    <= 1'b0;
		end else if (ce_i) begin
			state     <= next_state;
			sar       <= next_sar;
			mask      <= next_mask;
			trial_o   <= next_trial;
			left      <= next_left;
			start_q   <= lnk.start_n;
			eoc       <= next_eoc;
			data      <= next_data;
			ser       <= next_ser;
			bit_clk_o <= itick;
			busy_o    <= next_busy;
		end
	end

	// in external mode continuous pulses chain conversions: the pulse
	// after completion starts the next run, one result per N+1 pulses
	// (the idle branch above takes it), which is what gating relies on

endmodule // sarcs_device

/* logic/sarcs_host.sv */
// host end: register port, trigger and pulse generation, result capture
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module sarcs_host (
	// clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	// register port
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        we_i,
	input  wire logic        re_i,
	output logic [31:0]      rdata_o,
	output logic             irq_o,
	// link to converter
	sarcs_if.host            lnk
);

	sarcs_pkg::sarcs_hst_state_t state;
	sarcs_pkg::sarcs_hst_state_t next_state;

	logic        ext, cont, bufd, start_n, eoc_q;
	logic [3:0]  tap;
	logic [1:0]  rate, code, stat, imask, pcnt;
	logic [1:0]  res;
	logic [9:0]  cnt;
	logic [11:0] result;

	logic        next_ext, next_cont, next_bufd, next_start_n, next_irq;
	logic [3:0]  next_tap;
	logic [1:0]  next_rate, next_code, next_stat, next_imask, next_pcnt;
	logic [9:0]  next_cnt;
	logic [11:0] next_result;
	logic [31:0] next_rdata;

	logic ctrl_wr, go, eoc_fall, idle;

	assign ctrl_wr  = we_i & (addr_i == sarcs_pkg::REG_CTRL);
	assign go       = ctrl_wr & wdata_i[sarcs_pkg::CTRL_GO];
	assign eoc_fall = eoc_q & ~lnk.eoc;
	assign idle     = (state == sarcs_pkg::HST_IDLE);
	assign res      = wdata_i[sarcs_pkg::CTRL_RES_LSB +: 2];

	assign lnk.start_n  = start_n;
	assign lnk.ext_mode = ext;
	assign lnk.sc_tap   = tap;
	assign lnk.clk_rate = rate;
	assign lnk.code_sel = code;

	// configuration: frozen while busy except the continuous bit
	always_comb begin
		next_ext  = ext;
		next_bufd = bufd;
		next_tap  = tap;
		next_rate = rate;
		next_code = code;
		next_cont = cont;
		if (ctrl_wr) begin
			next_cont = wdata_i[sarcs_pkg::CTRL_CONT];
			if (idle) begin
				next_ext  = wdata_i[sarcs_pkg::CTRL_EXT];
				next_bufd = wdata_i[sarcs_pkg::CTRL_BUF];
				next_tap  = 4'(sarcs_pkg::res_bits(res) + 4'h1);
				next_rate = sarcs_pkg::res_rate(res);
				next_code = wdata_i[sarcs_pkg::CTRL_CODE_LSB +: 2];
			end
		end
	end

	// trigger sequencer; external period of 1 us is slower than any
	// internal bit period, so no resolution is overdriven
	always_comb begin
		next_state   = state;
		next_cnt     = 10'(cnt + 10'h1);
		next_start_n = 1'b1;
		next_pcnt    = pcnt;
		case (state)
			sarcs_pkg::HST_IDLE: begin
				next_cnt = '0;
				if (go) begin
					next_pcnt  = '0;
					next_state = next_bufd ? sarcs_pkg::HST_SETTLE : sarcs_pkg::HST_LOW;
					next_start_n = next_bufd;
				end
			end
			sarcs_pkg::HST_SETTLE: begin
				if (next_cnt == sarcs_pkg::SETTLE_CYC) begin
					next_cnt     = '0;
					next_state   = sarcs_pkg::HST_LOW;
					next_start_n = 1'b0;
				end
			end
			sarcs_pkg::HST_LOW: begin
				next_start_n = 1'b0;
				if (next_cnt == sarcs_pkg::START_LOW_CYC) begin
					next_cnt     = '0;
					next_start_n = 1'b1;
					next_pcnt    = (pcnt == 2'h2) ? pcnt : 2'(pcnt + 2'h1);
					next_state   = ext ? sarcs_pkg::HST_HIGH : sarcs_pkg::HST_WAIT;
				end
			end
			sarcs_pkg::HST_HIGH: begin
				if (next_cnt == sarcs_pkg::EXT_HIGH_CYC) begin
					next_cnt = '0;
					// with continuous off, eoc gates the train once a run has finished
					if (!cont && pcnt == 2'h2 && !lnk.eoc) begin
						next_state = sarcs_pkg::HST_IDLE;
					end else begin
						next_state   = sarcs_pkg::HST_LOW;
						next_start_n = 1'b0;
					end
				end
			end
			sarcs_pkg::HST_WAIT: begin
				next_cnt = '0;
				if (eoc_fall) begin
					next_state = !cont ? sarcs_pkg::HST_IDLE :
						bufd ? sarcs_pkg::HST_SETTLE : sarcs_pkg::HST_LOW;
					next_start_n = !cont | bufd;
				end
			end
			default: begin
				next_state = sarcs_pkg::HST_IDLE;
			end
		endcase
	end

	// capture, sticky status (set beats write-one clear) and interrupt
	always_comb begin
		logic [1:0] set, clr;
		set = '0;
		clr = '0;
		next_result = result;
		if (eoc_fall && !idle) begin
			next_result = lnk.data;
			set[sarcs_pkg::STAT_DONE] = 1'b1;
			set[sarcs_pkg::STAT_OVR]  = stat[sarcs_pkg::STAT_DONE];
		end
		if (we_i && addr_i == sarcs_pkg::REG_STAT)
			clr = wdata_i[1:0];
		next_stat  = (stat & ~clr) | set;
		next_imask = (we_i && addr_i == sarcs_pkg::REG_MASK) ? wdata_i[1:0] : imask;
		next_irq   = |(next_stat & next_imask);
	end

	// read data the cycle after the strobe, zero otherwise
	always_comb begin
		next_rdata = '0;
		if (!re_i)
			next_rdata = '0;
		else if (addr_i == sarcs_pkg::REG_CTRL)
			next_rdata = {24'h0, code, 2'(res_sel(tap)), bufd, cont, ext, 1'b0};
		else if (addr_i == sarcs_pkg::REG_STAT)
			next_rdata = {30'h0, stat};
		else if (addr_i == sarcs_pkg::REG_MASK)
			next_rdata = {30'h0, imask};
		else if (addr_i == sarcs_pkg::REG_RSLT)
			next_rdata = {19'h0, !idle, result};
	end

	// tap back to resolution code for readback
	function automatic logic [1:0] res_sel(input logic [3:0] t);
		if (t == 4'(sarcs_pkg::BITS_10 + 4'h1))
			return sarcs_pkg::RES_10;
		if (t == 4'(sarcs_pkg::BITS_8 + 4'h1))
			return sarcs_pkg::RES_8;
		return sarcs_pkg::RES_12;
	endfunction

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state   <= sarcs_pkg::HST_IDLE;
			ext     <= 1'b0;
			cont    <= 1'b0;
			bufd    <= 1'b0;
			tap     <= sarcs_pkg::TAP_FULL;
			rate    <= sarcs_pkg::RATE_GND;
			code    <= sarcs_pkg::CODE_UNI;
			start_n <= 1'b1;
			eoc_q   <= 1'b1;
			cnt     <= '0;
			pcnt    <= '0;
			result  <= '0;
			stat    <= '0;
			imask   <= '0;
			irq_o   <= 1'b0;
			rdata_o <= '0;
		end else if (ce_i) begin
			state   <= next_state;
			ext     <= next_ext;
			cont    <= next_cont;
			bufd    <= next_bufd;
			tap     <= next_tap;
			rate    <= next_rate;
			code    <= next_code;
			start_n <= next_start_n;
			eoc_q   <= lnk.eoc;
			cnt     <= next_cnt;
			pcnt    <= next_pcnt;
			result  <= next_result;
			stat    <= next_stat;
			imask   <= next_imask;
			irq_o   <= next_irq;
			rdata_o <= next_rdata;
		end
	end
endmodule // sarcs_host

/* verif/sarcs_link_assertions.sv */
// concurrent checks on the link between host logic and converter
`timescale 1ns/1ps
module sarcs_link_assertions (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// link signals
	input  wire logic        start_n,
	input  wire logic        ext_mode,
	input  wire logic [3:0]  sc_tap,
	input  wire logic [1:0]  clk_rate,
	input  wire logic [1:0]  code_sel,
	input  wire logic        eoc,
	input  wire logic [11:0] data,
	input  wire logic        ser
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic        start_q, eoc_q, run, st_fall;
	logic        next_start_q, next_eoc_q, next_run;
	logic [4:0]  pc, next_pc;
	logic [15:0] cyc, next_cyc, want;
	logic [3:0]  nbits;
	logic [7:0]  div;
	logic [11:0] low_mask;

	// bit count and bit period implied by the straps
	always_comb begin
		nbits = (sc_tap >= 4'h2 && sc_tap <= 4'hd) ? 4'(sc_tap - 4'h1) : 4'hc;
		div = (clk_rate == sarcs_pkg::RATE_5V) ? sarcs_pkg::BIT_5V_CYC :
			(clk_rate == sarcs_pkg::RATE_15V) ? sarcs_pkg::BIT_15V_CYC : sarcs_pkg::BIT_GND_CYC;
		want = 16'(nbits) * 16'(div);
		low_mask = 12'hfff >> nbits;
		st_fall = start_q & ~start_n;
	end

	// pulses and cycles since the trigger; saturate so idle time never wraps
	always_comb begin
		next_start_q = start_n;
		next_eoc_q = eoc;
		next_run = run;
		next_pc = pc;
		next_cyc = (cyc == 16'hffff) ? cyc : 16'(cyc + 16'h1);
		if (st_fall) begin
			next_pc = (run && ext_mode) ? 5'(pc + 5'h1) : 5'h1;
			next_run = 1'b1;
			next_cyc = 16'h0;
		end else if (eoc_q && !eoc) begin
			next_run = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			start_q <= 1'b1;
			eoc_q <= 1'b1;
			run <= 1'b0;
			pc <= 5'h0;
			cyc <= 16'h0;
		end else begin
			start_q <= next_start_q;
			eoc_q <= next_eoc_q;
			run <= next_run;
			pc <= next_pc;
			cyc <= next_cyc;
		end
	end

	trig_status_a: assert property ($fell(start_n) && (!ext_mode || !run) |=> eoc)
		else $error("status not raised by trigger");
	reset_status_a: assert property ($rose(rst_n_i) |-> eoc && data == 12'hfff)
		else $error("status or data wrong after reset");
	ext_pulses_a: assert property ($fell(eoc) && ext_mode |-> pc == 5'(nbits) + 5'h1)
		else $error("external conversion pulse count wrong");
	int_period_a: assert property ($fell(eoc) && !ext_mode |-> cyc + 16'h1 >= want && cyc <= want + 16'h2)
		else $error("internal conversion length wrong");
	trunc_ones_a: assert property ($fell(eoc) |-> (data & low_mask) == low_mask)
		else $error("unresolved bits not complemented ones");
	data_hold_a: assert property (!$fell(eoc) |-> $stable(data))
		else $error("parallel data moved between results");
	rate_strap_a: assert property ($fell(start_n) |->
		(sc_tap != 4'hb || clk_rate == sarcs_pkg::RATE_5V) && (sc_tap != 4'h9 || clk_rate == sarcs_pkg::RATE_15V))
		else $error("clock rate strap does not suit resolution");
	rate_limit_a: assert property ($fell(start_n) |-> sc_tap != 4'hd || clk_rate == sarcs_pkg::RATE_GND)
		else $error("full resolution run with a sped-up clock");
	ser_last_a: assert property ($fell(eoc) && code_sel != sarcs_pkg::CODE_CTC |-> ser == data[4'(4'hc - nbits)])
		else $error("serial bit differs from last result bit");
	ser_step_a: assert property (ext_mode && $changed(ser) |-> $past(st_fall))
		else $error("serial decision without external pulse");

	cover property ($fell(eoc) && ext_mode);
	cover property ($fell(eoc) && !ext_mode && nbits == 4'h8);
	cover property ($fell(eoc) && code_sel == sarcs_pkg::CODE_CTC);
endmodule // sarcs_link_assertions

/* verif/sar_conversion_sequencer_tb.sv */
// self-checking bench: host and converter ends joined over the link
`timescale 1ns/1ps
module sar_conversion_sequencer_tb;
	logic        clk_i, rst_n_i, we_i, re_i, cmp_i, irq_o;
	logic [3:0]  addr_i;
	logic [31:0] wdata_i, rdata_o, d, lfsr_state;
	logic [11:0] trial_o, vin;
	logic        bit_clk, busy;
	int          mismatches, samples_checked, n, ticks;

	sarcs_if lnk_if ();
	sarcs_host sarcs_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i),
		.we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o), .lnk(lnk_if));
	sarcs_device sarcs_device_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .lnk(lnk_if), .cmp_i(cmp_i),
		.trial_o(trial_o), .bit_clk_o(bit_clk), .busy_o(busy));
	sarcs_link_assertions sarcs_link_assertions_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_n(lnk_if.start_n),
		.ext_mode(lnk_if.ext_mode), .sc_tap(lnk_if.sc_tap), .clk_rate(lnk_if.clk_rate),
		.code_sel(lnk_if.code_sel), .eoc(lnk_if.eoc), .data(lnk_if.data), .ser(lnk_if.ser));

	// 200 mhz clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// ideal comparator; one cycle late, harmless as trials last many cycles
	always @(posedge clk_i) cmp_i <= (vin >= trial_o);

	// internal bit clock pulses seen, for the per-run tick count
	always @(posedge clk_i) begin
		if (!rst_n_i)
			ticks <= 0;
		else if (bit_clk)
			ticks <= ticks + 1;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// ideal n-bit approximation in the chosen complementary code
	function automatic logic [11:0] exp_code(input logic [11:0] v, input logic [3:0] nb, input logic [1:0] c);
		logic [11:0] r;
		r = v & ~(12'hfff >> nb);
		return (c == sarcs_pkg::CODE_CTC) ? {r[11], ~r[10:0]} : ~r;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		we_i <= 1'b1;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] q);
		@(posedge clk_i);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1 q = rdata_o;
	endtask

	task automatic close_out;
		$display("checked %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// one conversion from go to cleared status
	task automatic conv(input logic [1:0] res, input logic [1:0] c, input logic ext, input logic bf,
		input logic m, input logic [11:0] v);
		logic [3:0] nb;
		int         t0;
		nb = (res == 2'h1) ? 4'ha : (res == 2'h2) ? 4'h8 : 4'hc;
		vin = v;
		wr(sarcs_pkg::REG_MASK, {31'h0, m});
		wr(sarcs_pkg::REG_CTRL, {24'h0, c, res, bf, 1'b0, ext, 1'b1});
		n = 0;
		while (lnk_if.start_n !== 1'b0 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		check(32'(n >= int'(sarcs_pkg::SETTLE_CYC) - 2), 32'(bf));
		repeat (2) @(posedge clk_i);
		#1 check({31'h0, busy}, 32'h1);
		check({31'h0, lnk_if.eoc}, 32'h1);
		t0 = ticks;
		d = 32'h0;
		n = 0;
		while (d[0] !== 1'b1 && n < 3000) begin
			rd(sarcs_pkg::REG_STAT, d);
			n++;
		end
		check(d, 32'h1);
		check(32'(irq_o), 32'(m));
		rd(sarcs_pkg::REG_RSLT, d);
		check(d & 32'hfff, 32'(exp_code(v, nb, c)));
		check({31'h0, busy}, 32'h0);
		if (!ext)
			check(32'(ticks - t0), 32'(nb));
		wr(sarcs_pkg::REG_STAT, 32'h1);
		repeat (2) @(posedge clk_i);
		#1 check(32'(irq_o), 32'h0);
		// let a pulse train finish its last period
		repeat (300) @(posedge clk_i);
	endtask

	// hang guard, well above the expected run length
	initial begin
		repeat (95000) @(posedge clk_i);
		mismatches++;
		close_out;
	end

	initial begin
		rst_n_i = 1'b0;
		we_i = 1'b0;
		re_i = 1'b0;
		addr_i = 4'h0;
		wdata_i = 32'h0;
		vin = 12'h0;
		lfsr_state = 32'hda6607c1;
		mismatches = 0;
		samples_checked = 0;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// reset values, unmapped place ignored on write and reads zero
		check({31'h0, lnk_if.eoc}, 32'h1);
		check({20'h0, lnk_if.data}, 32'hfff);
		rd(sarcs_pkg::REG_CTRL, d);
		check(d, 32'h0);
		rd(sarcs_pkg::REG_MASK, d);
		check(d, 32'h0);
		wr(4'h2, 32'hffffffff);
		rd(4'h2, d);
		check(d, 32'h0);
		// every resolution and coding, both clock modes, random input
		for (int i = 0; i < 6; i++) begin
			for (int c = 0; c < 3; c++) begin
				lfsr_state = lfsr_next(lfsr_state);
				conv(2'(i % 3), 2'(c), i >= 3, lfsr_state[12], lfsr_state[13], lfsr_state[11:0]);
			end
		end
		// input at the range ends and midscale
		conv(2'h0, 2'h0, 1'b0, 1'b0, 1'b1, 12'h000);
		conv(2'h0, 2'h2, 1'b1, 1'b0, 1'b1, 12'hfff);
		conv(2'h2, 2'h1, 1'b0, 1'b1, 1'b0, 12'h800);
		// free-running pulses, 8 bits: a second result lands on unread status
		vin = 12'h5a3;
		wr(sarcs_pkg::REG_MASK, 32'h1);
		wr(sarcs_pkg::REG_CTRL, 32'h67);
		repeat (4000) @(posedge clk_i);
		rd(sarcs_pkg::REG_STAT, d);
		check(d, 32'h3);
		rd(sarcs_pkg::REG_RSLT, d);
		check(d & 32'hfff, 32'(exp_code(12'h5a3, 4'h8, 2'h1)));
		// drop continuous mode while busy; the train must stop
		wr(sarcs_pkg::REG_CTRL, 32'h62);
		repeat (3000) @(posedge clk_i);
		wr(sarcs_pkg::REG_STAT, 32'h3);
		n = 0;
		repeat (400) begin
			@(posedge clk_i);
			if (lnk_if.start_n === 1'b0)
				n++;
		end
		check(32'(n), 32'h0);
		check(32'(irq_o), 32'h0);
		// internal continuous runs, 8 bits: retriggered on each completion
		wr(sarcs_pkg::REG_CTRL, 32'h25);
		repeat (3000) @(posedge clk_i);
		rd(sarcs_pkg::REG_STAT, d);
		check(d, 32'h3);
		rd(sarcs_pkg::REG_RSLT, d);
		check(d & 32'hfff, 32'(exp_code(12'h5a3, 4'h8, 2'h0)));
		// continuous off while busy: the running conversion is the last
		wr(sarcs_pkg::REG_CTRL, 32'h20);
		repeat (1000) @(posedge clk_i);
		wr(sarcs_pkg::REG_STAT, 32'h3);
		n = 0;
		repeat (800) begin
			@(posedge clk_i);
			if (lnk_if.start_n === 1'b0)
				n++;
		end
		check(32'(n), 32'h0);
		close_out;
	end
endmodule // sar_conversion_sequencer_tb
